/* logic/adc_ctl_pkg.sv */
// constants for the converter control block: register map, bit fields,
// reset values and conversion lengths.
// assumes an 8-bit register port and a 125 MHz system clock.
package adc_ctl_pkg;
  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] ctrl_a_off = 8'h00;
  localparam logic [7:0] ctrl_b_off = 8'h01;
  localparam logic [7:0] in_sel_off = 8'h02;
  localparam logic [7:0] ev_stat_off = 8'h03;
  localparam logic [7:0] ev_clr_off = 8'h04;
  localparam logic [7:0] ev_en_off = 8'h05;
  // ----------------------------------------------------------------
  // converter_control_status_a fields
  // ----------------------------------------------------------------
  localparam int en_bit = 7;
  localparam int start_bit = 6;
  localparam int auto_bit = 5;
  localparam int flag_bit = 4;
  localparam int ie_bit = 3;
  // converter_control_status_b: input_select[5] and trigger_select
  localparam int insel_hi_bit = 3;
  // event status bits
  localparam int ev_done = 0;
  localparam int ev_abort = 1;
  localparam int ev_w = 2;
  // ----------------------------------------------------------------
  // reset values and timing
  // ----------------------------------------------------------------
  localparam logic [7:0] ctrl_a_rst = 8'h00;
  localparam logic [5:0] insel_rst = 6'h00;
  localparam logic [2:0] tsel_rst = 3'h0;
  localparam logic [4:0] first_len = 5'd25;
  localparam logic [4:0] normal_len = 5'd13;
  // gain codes on the select outputs
  localparam logic [1:0] gain_1x = 2'h0;
  localparam logic [1:0] gain_10x = 2'h1;
  localparam logic [1:0] gain_200x = 2'h2;
  typedef enum logic {st_idle, st_run} conv_state_t;
endpackage

/* logic/adc_conversion_control.sv */
// converter control: enable, start, auto trigger, done flag, prescaler
// and input select decoding in front of a successive-approx core.
// assumes the core samples its select outputs while core_busy is high
// and that all inputs are synchronous to mclk.
//
// Local design decisions: the address map and the plain strobed port.
`timescale 1ns/10ps
`default_nettype none

// Overview of operation
// - on bit powers converter, clearing turns off
// - clearing on bit aborts running conversion
// - single mode: each start write, one conversion
// - free running: start write launches first only
// - first conversion 25 adc clocks, later 13
// - start bit reads busy; writing zero ignored
// - auto trigger starts on selected rising edge
// - done flag set when conversion finishes
// - done flag cleared by vector or write one
// - irq request needs flag, enable, global enable
// - prescale field divides clock by 2 to 128
// - decode upper input select code space
// - codes 011110 bandgap, 011111 ground
// - select changes apply after conversion completes
// - choosing free running causes no trigger
module adc_conversion_control (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  input wire logic global_irq_enable,
  input wire logic irq_vector_ack,
  input wire logic [6:0] trig_in,
  output logic core_power,
  output logic core_busy,
  output logic core_init,
  output logic adc_tick,
  output logic result_load,
  output logic [5:0] mux_sel,
  output logic sel_single,
  output logic sel_diff,
  output logic sel_bandgap,
  output logic sel_ground,
  output logic sel_reserved,
  output logic [1:0] sel_gain,
  output logic [3:0] sel_pos,
  output logic [3:0] sel_neg,
  output logic done_irq_req,
  output logic irq
);
  import adc_ctl_pkg::*;

  typedef struct packed {
    conv_state_t st;
    logic en;
    logic busy;
    logic auto_on;
    logic flag;
    logic ie;
    logic [2:0] ps;
    logic [2:0] tsel;
    logic [5:0] insel;
    logic [5:0] mux;
    logic init_pend;
    logic is_init;
    logic [6:0] div_cnt;
    logic tick;
    logic [4:0] cnt;
    logic trig_prev;
    logic [ev_w-1:0] stat;
    logic [ev_w-1:0] ev_en;
    logic [7:0] rdata;
    logic result_load;
    logic irq;
    logic req;
    logic single;
    logic diff;
    logic bg;
    logic gnd;
    logic rsv;
    logic [1:0] gain;
    logic [3:0] pos;
    logic [3:0] neg;
  } ctl_state_t;

  ctl_state_t s;
  ctl_state_t n;
  logic wr_a;
  logic wr_b;
  logic wr_in;
  logic [6:0] div_last;
  logic [4:0] len;
  logic trig_now;
  logic complete;
  logic free_run;
  logic hw_start;
  logic sw_start;

  // ----------------------------------------------------------------
  // decode and derived terms
  // ----------------------------------------------------------------
  assign wr_a = wr && (addr == ctrl_a_off);
  assign wr_b = wr && (addr == ctrl_b_off);
  assign wr_in = wr && (addr == in_sel_off);
  // codes 0 and 1 both divide by two
  assign div_last = (s.ps < 3'h2) ? 7'h01 : 7'((8'h01 << s.ps) - 8'h01);
  assign len = s.is_init ? first_len : normal_len;
  assign complete = s.busy && s.tick && (s.cnt == len - 5'd1);
  assign free_run = (s.tsel == tsel_rst);
  // free running has no edge source, so selecting it raises no event
  assign trig_now = free_run ? 1'b0 : trig_in[s.tsel - 3'h1];
  assign hw_start = s.auto_on && (trig_now && !s.trig_prev);
  // a start write only counts together with the on bit set
  assign sw_start = wr_a && wdata[start_bit] && wdata[en_bit];

  always_comb begin
    n = s;
    n.tick = 1'b0;
    n.result_load = 1'b0;
    n.rdata = 8'h00;
    n.trig_prev = trig_now;
    // ----------------------------------------------------------------
    // adc clock prescaler
    // ----------------------------------------------------------------
    if (!s.en) begin
      n.div_cnt = 7'h00;
    end else if (s.div_cnt >= div_last) begin
      n.div_cnt = 7'h00;
      n.tick = 1'b1;
    end else begin
      n.div_cnt = s.div_cnt + 7'h01;
    end
    // ----------------------------------------------------------------
    // register writes
    // ----------------------------------------------------------------
    if (wr_a) begin
      n.en = wdata[en_bit];
      n.auto_on = wdata[auto_bit];
      n.ie = wdata[ie_bit];
      n.ps = wdata[2:0];
      if (wdata[flag_bit]) begin
        n.flag = 1'b0;
      end
      if (!s.en && wdata[en_bit]) begin
        n.init_pend = 1'b1;
      end
    end
    if (irq_vector_ack) begin
      n.flag = 1'b0;
    end
    if (wr_b) begin
      n.insel[5] = wdata[insel_hi_bit];
      n.tsel = wdata[2:0];
    end
    if (wr_in) begin
      n.insel[4:0] = wdata[4:0];
    end
    if (wr && (addr == ev_en_off)) begin
      n.ev_en = wdata[ev_w-1:0];
    end
    if (wr && (addr == ev_clr_off)) begin
      n.stat = s.stat & ~wdata[ev_w-1:0];
    end
    // ----------------------------------------------------------------
    // conversion sequencer
    // ----------------------------------------------------------------
    case (s.st)
      st_idle: begin
        // select follows the register only between conversions
        n.mux = n.insel;
        if (n.en && (sw_start || hw_start)) begin
          n.st = st_run;
          n.busy = 1'b1;
          n.cnt = 5'd0;
          n.is_init = n.init_pend;
          n.init_pend = 1'b0;
        end
      end
      st_run: begin
        // start writes are not looked at here, so nothing restarts
        if (!n.en) begin
          n.st = st_idle;
          n.busy = 1'b0;
          n.stat[ev_abort] = 1'b1;
        end else if (complete) begin
          n.result_load = 1'b1;
          n.flag = 1'b1;
          n.stat[ev_done] = 1'b1;
          n.mux = s.insel;
          n.cnt = 5'd0;
          n.is_init = 1'b0;
          if (s.auto_on && free_run) begin
            n.busy = 1'b1;
          end else begin
            n.st = st_idle;
            n.busy = 1'b0;
          end
        end else if (s.tick) begin
          n.cnt = s.cnt + 5'd1;
        end
      end
      default: begin
        n.st = st_idle;
      end
    endcase
    // ----------------------------------------------------------------
    // input select decode of the active code
    // ----------------------------------------------------------------
    n.single = 1'b0;
    n.diff = 1'b0;
    n.bg = 1'b0;
    n.gnd = 1'b0;
    n.rsv = 1'b0;
    n.gain = gain_1x;
    n.pos = 4'h0;
    n.neg = 4'h0;
    if (n.mux[4:3] == 2'b00) begin
      n.single = 1'b1;
      n.pos = {n.mux[5], n.mux[2:0]};
    end else if (n.mux[4:3] == 2'b01) begin
      n.diff = 1'b1;
      n.pos = {n.mux[5], 1'b0, n.mux[2], n.mux[0]};
      n.neg = {n.mux[5], 1'b0, n.mux[2], 1'b0};
      n.gain = n.mux[1] ? gain_200x : gain_10x;
    end else if (n.mux[4:1] == 4'b1111) begin
      // upper two codes are reserved, lower two are internal sources
      n.rsv = n.mux[5];
      n.single = !n.mux[5];
      n.bg = !n.mux[5] && !n.mux[0];
      n.gnd = !n.mux[5] && n.mux[0];
    end else begin
      n.diff = 1'b1;
      n.pos = {n.mux[5], n.mux[2:0]};
      n.neg = {n.mux[5], 1'b0, n.mux[3], !n.mux[3]};
    end
    // ----------------------------------------------------------------
    // interrupts and read port
    // ----------------------------------------------------------------
    n.irq = |(n.stat & n.ev_en);
    n.req = n.flag && n.ie && global_irq_enable;
    if (rd) begin
      if (addr == ctrl_a_off) begin
        n.rdata = {s.en, s.busy, s.auto_on, s.flag, s.ie, s.ps};
      end else if (addr == ctrl_b_off) begin
        n.rdata = {4'h0, s.insel[5], s.tsel};
      end else if (addr == in_sel_off) begin
        n.rdata = {3'h0, s.insel[4:0]};
      end else if (addr == ev_stat_off) begin
        n.rdata = {6'h00, s.stat};
      end else if (addr == ev_en_off) begin
        n.rdata = {6'h00, s.ev_en};
      end else begin
        n.rdata = 8'h00;
      end
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign rdata = s.rdata;
  assign core_power = s.en;
  assign core_busy = s.busy;
  assign core_init = s.is_init;
  assign adc_tick = s.tick;
  assign result_load = s.result_load;
  assign mux_sel = s.mux;
  assign sel_single = s.single;
  assign sel_diff = s.diff;
  assign sel_bandgap = s.bg;
  assign sel_ground = s.gnd;
  assign sel_reserved = s.rsv;
  assign sel_gain = s.gain;
  assign sel_pos = s.pos;
  assign sel_neg = s.neg;
  assign done_irq_req = s.req;
  assign irq = s.irq;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  logic [4:0] seen;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      seen <= 5'd0;
    end else if (!s.busy || s.result_load) begin
      seen <= 5'd0;
    end else if (s.tick) begin
      seen <= seen + 5'd1;
    end
  end

  default clocking @(posedge mclk); endclocking
  default disable iff (rst);

  chk_off_powers_down: assert property (wr_a && !wdata[en_bit] |=>
    !core_power ##1 !adc_tick) else $error("converter stays on");
  chk_off_aborts: assert property (core_busy && wr_a &&
    !wdata[en_bit] |=> !core_busy && !result_load) else $error("no abort");
  chk_single_start: assert property (!core_busy && sw_start |=>
    core_busy) else $error("start write lost");
  chk_conv_length: assert property (result_load |-> seen ==
    ($past(s.is_init) ? first_len : normal_len))
    else $error("wrong conversion length");
  chk_busy_readback: assert property (rd && addr == ctrl_a_off |=>
    rdata[start_bit] == $past(core_busy)) else $error("busy bit");
  chk_trig_starts: assert property (!core_busy && core_power &&
    !wr_a && hw_start |=> core_busy) else $error("trigger lost");
  chk_done_flag: assert property (complete && core_power &&
    !(wr_a && !wdata[en_bit]) |=> result_load && s.flag)
    else $error("done flag not set");
  chk_ack_clears: assert property (irq_vector_ack && !complete |=>
    !s.flag) else $error("flag not cleared");
  chk_irq_gate: assert property (done_irq_req |->
    $past(global_irq_enable) && s.flag && s.ie) else $error("ungated request");
  chk_tick_spacing: assert property (adc_tick && s.ps > 3'h1 &&
    !wr_a |=> !adc_tick ##1 !adc_tick) else $error("adc clock too fast");
  chk_select_hold: assert property (core_busy &&
    $past(core_busy) && !result_load |-> $stable(mux_sel))
    else $error("select moved");
  chk_no_restart: assert property (core_busy && sw_start &&
    !s.tick && !complete |=> s.cnt == $past(s.cnt)) else $error("restart");
endmodule
`default_nettype wire

/* tb/adc_core_model.sv */
// model of the analog core: counts adc clock ticks in each conversion
// and the result loads it is asked for.
// assumes busy, tick and load come from the control block on mclk.
`timescale 1ns/10ps
`default_nettype none
module adc_core_model (
  input wire logic mclk,
  input wire logic rst,
  input wire logic core_busy,
  input wire logic adc_tick,
  input wire logic result_load,
  output logic [7:0] last_len,
  output logic [7:0] loads
);
  logic [7:0] cnt;
  // ----------------------------------------------------------------
  // tick count per conversion
  // ----------------------------------------------------------------
  // a load closes the count, so back to back conversions stay apart
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cnt <= 8'h00;
      last_len <= 8'h00;
      loads <= 8'h00;
    end else if (result_load) begin
      last_len <= cnt;
      loads <= loads + 8'h01;
      cnt <= 8'h00;
    end else if (!core_busy) begin
      cnt <= 8'h00;
    end else if (adc_tick) begin
      cnt <= cnt + 8'h01;
    end
  end
endmodule
`default_nettype wire

/* tb/adc_conversion_control_tb.sv */
// register level test of the converter control block.
// assumes the core model only observes; all stimulus comes from here.
`timescale 1ns/10ps
`default_nettype none
module adc_conversion_control_tb;
  import adc_ctl_pkg::*;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic global_irq_enable = 1'b0;
  logic irq_vector_ack = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic [6:0] trig_in = 7'h00;
  logic [7:0] rdata, len, loads, v, l0;
  logic core_power, core_busy, core_init, adc_tick, result_load;
  logic sel_single, sel_diff, sel_bandgap, sel_ground, sel_reserved;
  logic done_irq_req, irq;
  logic [5:0] mux_sel, s;
  logic [1:0] sel_gain;
  logic [3:0] sel_pos, sel_neg;
  int errors, total_checks, g;

  adc_conversion_control adc_conversion_control_inst (.mclk(mclk),
    .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .global_irq_enable(global_irq_enable),
    .irq_vector_ack(irq_vector_ack), .trig_in(trig_in),
    .core_power(core_power), .core_busy(core_busy),
    .core_init(core_init), .adc_tick(adc_tick),
    .result_load(result_load), .mux_sel(mux_sel),
    .sel_single(sel_single), .sel_diff(sel_diff),
    .sel_bandgap(sel_bandgap), .sel_ground(sel_ground),
    .sel_reserved(sel_reserved), .sel_gain(sel_gain),
    .sel_pos(sel_pos), .sel_neg(sel_neg),
    .done_irq_req(done_irq_req), .irq(irq));
  adc_core_model adc_core_model_inst (.mclk(mclk), .rst(rst),
    .core_busy(core_busy), .adc_tick(adc_tick),
    .result_load(result_load), .last_len(len), .loads(loads));

  initial begin
    forever #4 mclk = ~mclk;
  end
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task automatic summarize;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask
  task automatic rreg(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  // a missing load ends the run instead of hanging it
  task automatic wait_load(input int lim);
    int n;
    n = 0;
    // look 1 ns after each edge so the pulse is settled when sampled
    @(posedge mclk);
    #1;
    while (result_load !== 1'b1) begin
      n++;
      if (n > lim) begin
        $display("CHECK FAILED t=%0t no result load", $time);
        errors++;
        summarize();
      end
      @(posedge mclk);
      #1;
    end
    @(posedge mclk);
    #1;
  endtask
  task automatic tick_gap(output int gap);
    int p;
    p = -1;
    gap = 0;
    for (int i = 0; i < 300 && gap == 0; i++) begin
      @(posedge mclk);
      if (adc_tick === 1'b1 && p >= 0) gap = i - p;
      if (adc_tick === 1'b1) p = i;
    end
  endtask
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (8) @(posedge mclk);
    rst <= 1'b0;
    for (int a = 0; a < 7; a++) begin
      rreg(a < 6 ? 8'(a) : 8'h10, v);
      chk(v, 8'h00);
    end
    wreg(8'h00, 8'hc2);
    #1 chk({core_power, core_busy, core_init}, 3'b111);
    rreg(8'h00, v);
    chk(v, 8'hc2);
    wreg(8'h00, 8'hc2);
    wait_load(2000);
    chk(len, 8'd25);
    chk(loads, 8'd1);
    rreg(8'h00, v);
    chk(v, 8'h92);
    wreg(8'h00, 8'h82);
    repeat (3) @(posedge mclk);
    rreg(8'h00, v);
    chk({core_busy, v}, 9'h092);
    wreg(8'h00, 8'hc2);
    #1 chk({core_busy, core_init}, 2'b10);
    wait_load(2000);
    chk(len, 8'd13);
    repeat (120) @(posedge mclk);
    chk(loads, 8'd2);
    wreg(8'h00, 8'h8a);
    repeat (3) @(posedge mclk);
    chk(done_irq_req, 1'b0);
    global_irq_enable <= 1'b1;
    repeat (3) @(posedge mclk);
    chk(done_irq_req, 1'b1);
    irq_vector_ack <= 1'b1;
    @(posedge mclk);
    irq_vector_ack <= 1'b0;
    rreg(8'h00, v);
    chk({done_irq_req, v}, 9'h08a);
    wreg(8'h05, 8'h01);
    wreg(8'h00, 8'hca);
    wait_load(2000);
    repeat (2) @(posedge mclk);
    rreg(8'h03, v);
    chk({irq, done_irq_req, v}, 10'h301);
    wreg(8'h00, 8'h9a);
    wreg(8'h04, 8'h01);
    repeat (2) @(posedge mclk);
    rreg(8'h00, v);
    chk({irq, done_irq_req, v}, 10'h08a);
    wreg(8'h05, 8'h00);
    l0 = loads;
    wreg(8'h00, 8'hc2);
    repeat (10) @(posedge mclk);
    wreg(8'h00, 8'h02);
    repeat (2) @(posedge mclk);
    #1 chk({core_power, core_busy}, 2'b00);
    repeat (200) @(posedge mclk);
    rreg(8'h03, v);
    chk({irq, v, loads}, {1'b0, 8'h02, l0});
    wreg(8'h04, 8'h03);
    for (int c = 0; c < 8; c++) begin
      wreg(8'h00, 8'hc0 | 8'(c));
      tick_gap(g);
      chk(16'(g), c < 2 ? 16'd2 : 16'd1 << c);
      wait_load(4000);
    end
    for (int c = 30; c < 64; c++) begin
      s = 6'(c);
      wreg(8'h01, {4'h0, s[5], 3'h0});
      wreg(8'h02, {3'h0, s[4:0]});
      repeat (2) @(posedge mclk);
      #1 chk(mux_sel, s);
      chk({sel_diff, sel_bandgap, sel_ground, sel_reserved},
        {s[5:3] == 3'b101 || (s[5:4] == 2'b11 && s < 6'h3e),
        s == 6'h1e, s == 6'h1f, s > 6'h3d});
      if (s[5:3] == 3'b100)
        chk({sel_single, sel_pos}, {2'b11, s[2:0]});
      if (s[5:3] == 3'b101)
        chk({sel_gain, sel_pos, sel_neg}, {s[1] ? gain_200x : gain_10x,
          2'b10, s[2], s[0], 2'b10, s[2], 1'b0});
      if (s[5:4] == 2'b11 && s < 6'h3e)
        chk({sel_gain, sel_pos, sel_neg}, {gain_1x, 1'b1, s[2:0],
          2'b10, s[3], ~s[3]});
    end
    wreg(8'h01, 8'h08);
    wreg(8'h02, 8'h00);
    wreg(8'h00, 8'hc1);
    wreg(8'h02, 8'h05);
    repeat (3) @(posedge mclk);
    #1 chk(mux_sel, 6'h20);
    wait_load(2000);
    @(posedge mclk);
    #1 chk(mux_sel, 6'h25);
    wreg(8'h01, 8'h00);
    l0 = loads;
    wreg(8'h00, 8'he1);
    repeat (3) wait_load(2000);
    chk({core_busy, loads}, {1'b1, l0 + 8'd3});
    wreg(8'h00, 8'h81);
    wait_load(2000);
    repeat (60) @(posedge mclk);
    chk(core_busy, 1'b0);
    wreg(8'h01, 8'h01);
    wreg(8'h00, 8'ha1);
    wreg(8'h01, 8'h00);
    repeat (10) @(posedge mclk);
    chk(core_busy, 1'b0);
    for (int k = 1; k < 8; k++) begin
      l0 = loads;
      wreg(8'h01, 8'(k));
      repeat (2) @(posedge mclk);
      trig_in <= 7'h01 << (k - 1);
      wait_load(2000);
      @(posedge mclk);
      trig_in <= 7'h00;
      chk(loads, l0 + 8'd1);
      repeat (3) @(posedge mclk);
    end
    // second reset with the converter on but idle: everything must fall back to off
    rst <= 1'b1;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    #1 chk({core_power, core_busy, irq, done_irq_req}, 4'h0);
    rreg(8'h00, v);
    chk(v, 8'h00);
    summarize();
  end
endmodule
`default_nettype wire
